// ===== design/dam_alarm_monitor.sv
// Purpose: Alarm supervision of a DC drive converter
// Assumes: all inputs synchronous to CORE_CLK; plain register port
// Notes:   Alarm flags follow their causes; only the interrupt status is sticky
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// (R1) Alarms need no acknowledge; each clears once its cause is gone.
// (R2) Many alarms may be active; the panel shows them one after another.
// (R3) Any alarm sets status bit 7 and clears the no-alarm bit.
// (R4) Each active alarm sets its own bit in eight alarm words.
// (R5) Active alarm flashes the red LED on both panels and shows the code.
// (R6) Basic panel shows letter A plus the three-digit alarm number.
// (R7) External alarm one after control word 2 bit 28 low past delay 003.
// (R8) External alarm two after control word 2 bit 29 low past delay 004.
// (R9) Four block alarms follow selected binectors of index 001 and 002.
// (R10) Brush alarm when enabled and brush sensor low over 10 s.
// (R11) Bearing alarm when enabled and bearing sensor low over 2 s.
// (R12) Short on any binary select output raises an alarm in all states.
// (R13) Ring start alarm while link board initialized but not yet exchanging.
// (R14) Each alarm is suppressed outside its allowed operating states.
// (R15) Fault codes 101 to 147 are reserved for supplementary boards.
// (R16) Low checks count per source, restart and clear when signal goes high.
module dam_alarm_monitor
  import dam_pkg::*;
#(
  parameter logic [DAM_CNT_W-1:0] BRUSH_CYC   = DAM_BRUSH_CYC_DEF,
  parameter logic [DAM_CNT_W-1:0] BEARING_CYC = DAM_BEARING_CYC_DEF,
  parameter logic [DAM_CNT_W-1:0] FLASH_CYC   = DAM_FLASH_CYC_DEF,
  parameter logic [DAM_CNT_W-1:0] HOLD_CYC    = DAM_HOLD_CYC_DEF,
  parameter int unsigned          CYC_PER_MS  = DAM_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                                      CORE_CLK,
  input  wire logic                                      RST_B,
  // Register port
  input  wire logic [dam_pkg::DAM_ADDR_W-1:0]            REG_ADDR,
  input  wire logic [dam_pkg::DAM_DATA_W-1:0]            REG_WDATA,
  input  wire logic                                      REG_WR,
  input  wire logic                                      REG_RD,
  output logic      [dam_pkg::DAM_DATA_W-1:0]            REG_RDATA,
  output logic                                           IRQ,
  // Alarm sources
  input  wire logic [31:0]                               CONTROL_WORD2,
  input  wire logic [1:0]                                BLOCK_ALARM_SELECT_A,
  input  wire logic [1:0]                                BLOCK_ALARM_SELECT_B,
  input  wire logic                                      BRUSH_SENSE,
  input  wire logic                                      BEARING_SENSE,
  input  wire logic                                      SHORT_DETECT,
  input  wire logic                                      RING_INIT_DONE,
  input  wire logic                                      RING_EXCHANGE_OK,
  input  wire logic [dam_pkg::DAM_STATE_W-1:0]           OP_STATE,
  input  wire logic [7:0]                                FAULT_CODE,
  // Status outputs
  output logic                                           ALARM_PRESENT_BIT,
  output logic                                           NO_ALARM_BIT,
  output logic      [15:0]                               STATUS_WORD1,
  output logic      [dam_pkg::DAM_N_WORDS*dam_pkg::DAM_WORD_W-1:0] ALARM_CONNECTORS,
  output logic                                           SUPP_FAULT,
  // Panels
  output logic                                           BASIC_PANEL_LED,
  output logic                                           COMFORT_PANEL_LED,
  output logic      [7:0]                                BASIC_PANEL_LETTER,
  output logic      [11:0]                               BASIC_PANEL_CODE,
  output logic      [11:0]                               COMFORT_PANEL_CODE,
  output logic                                           PANEL_SHOWING
);
  import dam_pkg::*;

  localparam int NW = DAM_N_WORDS * DAM_WORD_W;

  typedef struct packed {
    logic [DAM_N_ALM-1:0] alarm;
    logic [DAM_N_ALM-1:0] irq_stat;
    logic [DAM_N_ALM-1:0] irq_mask;
    logic                 brush_en;
    logic                 bearing_en;
    logic [15:0]          dly1;
    logic [15:0]          dly2;
    logic [DAM_DATA_W-1:0] rdata;
    logic [DAM_CNT_W-1:0] flash_cnt;
    logic                 led;
    logic                 supp;
  } dam_state_t;

  dam_state_t st_r, st_nxt;

  logic                 ext1_tmr;
  logic                 ext2_tmr;
  logic                 brush_tmr;
  logic                 bearing_tmr;
  logic [DAM_N_ALM-1:0] raw;
  logic [DAM_N_ALM-1:0] qual;
  logic [NW-1:0]        words;
  logic [DAM_CNT_W-1:0] lim1;
  logic [DAM_CNT_W-1:0] lim2;
  logic [11:0]          scan_code;
  logic                 scan_show;
  logic                 any_alarm;

  assign lim1 = DAM_CNT_W'(st_r.dly1) * DAM_CNT_W'(CYC_PER_MS); // R7
  assign lim2 = DAM_CNT_W'(st_r.dly2) * DAM_CNT_W'(CYC_PER_MS); // R8

  dam_low_timer #(.CNT_W(DAM_CNT_W)) u_ext1 (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .enable (1'b1),
    .level  (CONTROL_WORD2[DAM_CW2_EXT1_BIT]),
    .limit  (lim1),
    .alarm  (ext1_tmr)
  );

  dam_low_timer #(.CNT_W(DAM_CNT_W)) u_ext2 (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .enable (1'b1),
    .level  (CONTROL_WORD2[DAM_CW2_EXT2_BIT]),
    .limit  (lim2),
    .alarm  (ext2_tmr)
  );

  dam_low_timer #(.CNT_W(DAM_CNT_W)) u_brush (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .enable (st_r.brush_en),
    .level  (BRUSH_SENSE),
    .limit  (BRUSH_CYC),
    .alarm  (brush_tmr)
  );

  dam_low_timer #(.CNT_W(DAM_CNT_W)) u_bearing (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .enable (st_r.bearing_en),
    .level  (BEARING_SENSE),
    .limit  (BEARING_CYC),
    .alarm  (bearing_tmr)
  );

  // Raw causes, one per alarm slot
  always_comb begin
    raw                = '0;
    raw[DAM_I_RING]    = RING_INIT_DONE && !RING_EXCHANGE_OK; // R13
    raw[DAM_I_SHORT]   = SHORT_DETECT; // R12
    raw[DAM_I_FB_C]    = BLOCK_ALARM_SELECT_A[1]; // R9
    raw[DAM_I_FB_D]    = BLOCK_ALARM_SELECT_B[1]; // R9
    raw[DAM_I_EXT1]    = ext1_tmr; // R7
    raw[DAM_I_EXT2]    = ext2_tmr; // R8
    raw[DAM_I_FB_A]    = BLOCK_ALARM_SELECT_A[0]; // R9
    raw[DAM_I_FB_B]    = BLOCK_ALARM_SELECT_B[0]; // R9
    raw[DAM_I_BRUSH]   = brush_tmr; // R10
    raw[DAM_I_BEARING] = bearing_tmr; // R11
  end

  // Operating-state qualification
  genvar gi;
  generate
    for (gi = 0; gi < DAM_N_ALM; gi++) begin : g_qual
      assign qual[gi] = raw[gi] && DAM_ALLOW[gi][OP_STATE]; // R14
    end
  endgenerate

  // Alarm word bank: alarm n sits at bit n-1
  always_comb begin
    words = '0;
    for (int i = 0; i < DAM_N_ALM; i++) begin
      words[DAM_ALM_NUM[i] - 1] = st_r.alarm[i]; // R4
    end
  end

  assign any_alarm = |st_r.alarm;

  always_comb begin
    st_nxt = st_r;
    // Flags follow their causes, nothing to acknowledge
    st_nxt.alarm = qual; // R1
    // Register reads and read-clear of the interrupt status
    st_nxt.rdata = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        DAM_A_CTRL:   st_nxt.rdata = DAM_DATA_W'({st_r.bearing_en, st_r.brush_en});
        DAM_A_DLY1:   st_nxt.rdata = DAM_DATA_W'(st_r.dly1);
        DAM_A_DLY2:   st_nxt.rdata = DAM_DATA_W'(st_r.dly2);
        DAM_A_WORDS:  st_nxt.rdata = words[DAM_DATA_W-1:0];
        DAM_A_ISTAT:  st_nxt.rdata = DAM_DATA_W'(st_r.irq_stat);
        DAM_A_IMASK:  st_nxt.rdata = DAM_DATA_W'(st_r.irq_mask);
        DAM_A_STATUS: st_nxt.rdata = DAM_DATA_W'({scan_code, !any_alarm, any_alarm});
        default:      st_nxt.rdata = '0;
      endcase
    end
    if (REG_RD && REG_ADDR == DAM_A_ISTAT) begin
      st_nxt.irq_stat = '0;
    end
    // New alarms win over a clearing read in the same cycle
    st_nxt.irq_stat = st_nxt.irq_stat | (qual & ~st_r.alarm);
    if (REG_WR) begin
      unique case (REG_ADDR)
        DAM_A_CTRL: begin
          st_nxt.brush_en   = REG_WDATA[DAM_CTRL_BRUSH]; // R10
          st_nxt.bearing_en = REG_WDATA[DAM_CTRL_BEARING]; // R11
        end
        DAM_A_DLY1:  st_nxt.dly1     = REG_WDATA[15:0];
        DAM_A_DLY2:  st_nxt.dly2     = REG_WDATA[15:0];
        DAM_A_IMASK: st_nxt.irq_mask = REG_WDATA[DAM_N_ALM-1:0];
        default: ;
      endcase
    end
    // Red LED flashes while any alarm is active
    // Preloaded so the first alarm cycle toggles the LED on at once
    if (!any_alarm) begin
      st_nxt.flash_cnt = FLASH_CYC - DAM_CNT_W'(1);
      st_nxt.led       = 1'b0;
    end else if (st_r.flash_cnt >= FLASH_CYC - DAM_CNT_W'(1)) begin
      st_nxt.flash_cnt = '0;
      st_nxt.led       = !st_r.led; // R5
    end else begin
      st_nxt.flash_cnt = st_r.flash_cnt + DAM_CNT_W'(1);
    end
    // Reserved supplementary-board fault range
    st_nxt.supp = (FAULT_CODE >= DAM_SUPP_FIRST) && (FAULT_CODE <= DAM_SUPP_LAST); // R15
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r      <= '0;
      st_r.dly1 <= DAM_DLY_RST;
      st_r.dly2 <= DAM_DLY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  dam_panel_scan #(.N(DAM_N_ALM), .CNT_W(DAM_CNT_W)) u_scan (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .active   (st_r.alarm),
    .hold_cyc (HOLD_CYC),
    .code     (scan_code),
    .showing  (scan_show)
  );

  assign REG_RDATA          = st_r.rdata;
  assign IRQ                = |(st_r.irq_stat & st_r.irq_mask);
  assign ALARM_PRESENT_BIT  = any_alarm; // R3
  assign NO_ALARM_BIT       = !any_alarm; // R3
  assign STATUS_WORD1       = 16'(any_alarm) << DAM_STATUS_BIT; // R3
  assign ALARM_CONNECTORS   = words; // R4
  assign SUPP_FAULT         = st_r.supp;
  assign BASIC_PANEL_LED    = st_r.led; // R5
  assign COMFORT_PANEL_LED  = st_r.led; // R5
  assign BASIC_PANEL_LETTER = scan_show ? DAM_LETTER_A : 8'h00; // R6
  assign BASIC_PANEL_CODE   = scan_code; // R6
  assign COMFORT_PANEL_CODE = scan_code; // R5
  assign PANEL_SHOWING      = scan_show;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  a_alarm_selfclr: assert property (!raw[DAM_I_SHORT] |=> !st_r.alarm[DAM_I_SHORT]) // R1
    else $error("short alarm stayed after cause ended");
  a_short_raise: assert property (SHORT_DETECT |=> ALARM_PRESENT_BIT && !NO_ALARM_BIT) // R12
    else $error("short did not raise alarm");
  a_status_bits: assert property (STATUS_WORD1[DAM_STATUS_BIT] == (st_r.alarm != '0)) // R3
    else $error("status bit 7 disagrees with alarms");
  a_ring_start: assert property (RING_INIT_DONE && !RING_EXCHANGE_OK // R13
    |=> ALARM_CONNECTORS[DAM_ALM_NUM[DAM_I_RING] - 1])
    else $error("ring start alarm missing");
  a_block_word: assert property (BLOCK_ALARM_SELECT_B[0] // R9
    |=> ALARM_CONNECTORS[DAM_ALM_NUM[DAM_I_FB_B] - 1])
    else $error("block alarm word bit missing");
  a_led_dark: assert property (!any_alarm[*2] |-> !BASIC_PANEL_LED) // R5
    else $error("red LED lit with no alarm");
  a_brush_gate: assert property (!st_r.brush_en |=> !brush_tmr) // R10
    else $error("brush alarm while sensing disabled");
  a_irq_read: assert property (REG_RD && REG_ADDR == DAM_A_ISTAT
    && $stable(st_r.alarm) && st_r.alarm == qual |=> st_r.irq_stat == '0)
    else $error("status read did not clear");
endmodule

// ===== design/dam_low_timer.sv
// Purpose: Low-duration check on one monitored level
// Assumes: level synchronous to clk
// Notes:   Alarm rises once the level has been low for more than limit cycles
`timescale 1ns/1ps
module dam_low_timer #(
  parameter int CNT_W = 34
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Check
  input  wire logic             enable,
  input  wire logic             level,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  alarm
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             alarm;
  } dam_tmr_t;
  dam_tmr_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!enable || level) begin
      st_nxt.cnt   = '0; // R16
      st_nxt.alarm = 1'b0; // R16
    end else begin
      if (st_r.cnt <= limit) begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1); // R16
      end
      st_nxt.alarm = (st_nxt.cnt > limit);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign alarm = st_r.alarm;

  a_clear_on_high: assert property (@(posedge clk) disable iff (!rst_b) // R16
    level |=> !alarm) else $error("alarm held after level returned high");
  a_rise_after_low: assert property (@(posedge clk) disable iff (!rst_b) // R16
    $rose(alarm) |-> !$past(level) && $past(enable) && st_r.cnt > limit)
    else $error("alarm rose without a long enough low");
endmodule

// ===== design/dam_panel_scan.sv
// Purpose: Cycles the panel display through all active alarms
// Assumes: active vector registered upstream
// Notes:   Each alarm stays on the display for hold_cyc+1 cycles
`timescale 1ns/1ps
module dam_panel_scan
  import dam_pkg::*;
#(
  parameter int N     = 10,
  parameter int CNT_W = 34
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Alarms
  input  wire logic [N-1:0]     active,
  input  wire logic [CNT_W-1:0] hold_cyc,
  // Display
  output logic [11:0]           code,
  output logic                  showing
);
  localparam int IW = $clog2(N);
  typedef struct packed {
    logic [IW-1:0]    idx;
    logic [CNT_W-1:0] hold;
    logic [11:0]      code;
    logic             show;
  } dam_scan_t;
  dam_scan_t st_r, st_nxt;
  logic [IW-1:0] next_idx;

  always_comb begin
    logic found;
    int   j;
    found    = 1'b0;
    j        = 0;
    next_idx = st_r.idx;
    for (int k = 1; k <= N; k++) begin
      j = (int'(st_r.idx) + k) % N;
      if (!found && active[j]) begin
        found    = 1'b1;
        next_idx = IW'(j);
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (active == '0) begin
      st_nxt.show = 1'b0;
      st_nxt.hold = '0;
      st_nxt.code = '0;
    end else if (!st_r.show || !active[st_r.idx] || st_r.hold >= hold_cyc) begin
      st_nxt.idx  = next_idx; // R2
      st_nxt.hold = '0;
      st_nxt.code = DAM_ALM_BCD[next_idx]; // R6
      st_nxt.show = 1'b1;
    end else begin
      st_nxt.hold = st_r.hold + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign code    = st_r.code;
  assign showing = st_r.show;

  a_show_tracks: assert property (@(posedge clk) disable iff (!rst_b) // R2
    active != '0 |=> showing) else $error("display blank while alarms active");
  a_shown_active: assert property (@(posedge clk) disable iff (!rst_b) // R2
    showing |-> |($past(active) & (N'(1) << st_r.idx)))
    else $error("display shows an inactive alarm");
endmodule

// ===== design/dam_pkg.sv
// Purpose: Shared constants of the drive alarm monitor
// Assumes: 125 MHz core clock
// Notes:   Alarm slots are ordered as listed in DAM_ALM_NUM
package dam_pkg;
  localparam int          DAM_N_ALM    = 10;
  localparam int          DAM_CNT_W    = 34;
  localparam int          DAM_ADDR_W   = 8;
  localparam int          DAM_DATA_W   = 32;
  localparam int          DAM_N_WORDS  = 8;
  localparam int          DAM_WORD_W   = 16;
  localparam int          DAM_STATE_W  = 5;
  // Timing
  localparam int unsigned DAM_CLK_HZ        = 125_000_000;
  localparam int unsigned DAM_MS_PER_S      = 1000;
  localparam int unsigned DAM_CYC_PER_MS    = DAM_CLK_HZ / DAM_MS_PER_S;
  localparam int unsigned DAM_BRUSH_TIME_S  = 10;
  localparam int unsigned DAM_BEARING_TIME_S = 2;
  localparam int unsigned DAM_FLASH_HALF_MS = 250;
  localparam int unsigned DAM_HOLD_MS       = 1000;
  localparam logic [DAM_CNT_W-1:0] DAM_BRUSH_CYC_DEF =
    DAM_CNT_W'(DAM_BRUSH_TIME_S * DAM_CLK_HZ);
  localparam logic [DAM_CNT_W-1:0] DAM_BEARING_CYC_DEF =
    DAM_CNT_W'(DAM_BEARING_TIME_S * DAM_CLK_HZ);
  localparam logic [DAM_CNT_W-1:0] DAM_FLASH_CYC_DEF =
    DAM_CNT_W'(DAM_FLASH_HALF_MS * DAM_CYC_PER_MS);
  localparam logic [DAM_CNT_W-1:0] DAM_HOLD_CYC_DEF =
    DAM_CNT_W'(DAM_HOLD_MS * DAM_CYC_PER_MS);
  // Alarm slots: decimal numbers and their three-digit display codes
  localparam int DAM_ALM_NUM [DAM_N_ALM] = '{15, 18, 19, 20, 21, 22, 23, 24, 25, 26};
  localparam logic [11:0] DAM_ALM_BCD [DAM_N_ALM] = '{12'h015, 12'h018, 12'h019,
    12'h020, 12'h021, 12'h022, 12'h023, 12'h024, 12'h025, 12'h026};
  localparam int DAM_I_RING = 0, DAM_I_SHORT = 1, DAM_I_FB_C = 2, DAM_I_FB_D = 3;
  localparam int DAM_I_EXT1 = 4, DAM_I_EXT2 = 5, DAM_I_FB_A = 6, DAM_I_FB_B = 7;
  localparam int DAM_I_BRUSH = 8, DAM_I_BEARING = 9;
  // Operating states in which each alarm may be active (bit per state)
  localparam logic [31:0] DAM_ALLOW [DAM_N_ALM] = '{default: 32'hFFFF_FFFF};
  localparam logic [7:0]  DAM_LETTER_A      = 8'h41;
  localparam int          DAM_STATUS_BIT    = 7;
  localparam int          DAM_CW2_EXT1_BIT  = 28;
  localparam int          DAM_CW2_EXT2_BIT  = 29;
  localparam logic [7:0]  DAM_SUPP_FIRST    = 8'h65;
  localparam logic [7:0]  DAM_SUPP_LAST     = 8'h93;
  // Register map
  localparam logic [DAM_ADDR_W-1:0] DAM_A_CTRL   = 8'h00;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_DLY1   = 8'h04;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_DLY2   = 8'h08;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_WORDS  = 8'h0C;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_ISTAT  = 8'h10;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_IMASK  = 8'h14;
  localparam logic [DAM_ADDR_W-1:0] DAM_A_STATUS = 8'h18;
  localparam int DAM_CTRL_BRUSH = 0;
  localparam int DAM_CTRL_BEARING = 1;
  localparam logic [15:0] DAM_DLY_RST = 16'h0000;
endpackage

// ===== tb/dam_panel_model.sv
// Purpose: Operator panel model that records which alarm codes were shown
// Assumes: panel outputs registered on clk
// Notes:   seen has bit n set once alarm number n was on the display
`timescale 1ns/1ps
module dam_panel_model (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        clr,
  // Panel side of the monitor
  input  wire logic        showing,
  input  wire logic [7:0]  letter,
  input  wire logic [11:0] code,
  input  wire logic [11:0] code_c,
  input  wire logic        led_a,
  input  wire logic        led_b,
  // Observations
  output logic      [31:0] seen,
  output logic      [7:0]  led_flips,
  output logic      [7:0]  bad
);
  logic       led_q;
  logic [7:0] num;

  // Lower two of the three BCD digits to a decimal alarm number
  assign num = 8'(code[7:4]) * 8'h0A + 8'(code[3:0]);

  always_ff @(posedge clk) begin
    led_q <= led_a;
    if (clr) begin
      seen      <= '0;
      led_flips <= '0;
      bad       <= '0;
    end else begin
      if (showing) begin
        seen[num[4:0]] <= 1'b1;
      end
      if (led_a !== led_q) begin
        led_flips <= led_flips + 8'h01;
      end
      if ((led_a !== led_b) || (showing && letter !== 8'h41) || (code_c !== code)) begin
        bad <= bad + 8'h01;
      end
    end
  end
endmodule

// ===== tb/drive_alarm_monitor_test.sv
// Purpose: Self-checking bench of the drive alarm monitor
// Assumes: shortened timing parameters; ms delay is MS cycles
// Notes:   Direct sources run from a table; timing, interrupt, panel by hand
`timescale 1ns/1ps
module drive_alarm_monitor_test;
  import dam_pkg::*;
  localparam int BR_L = 20;
  localparam int BE_L = 10;
  localparam int MS   = 2;
  typedef struct packed {
    logic [6:0]  src;
    logic [7:0]  fc;
    logic [31:0] exp;
    logic        supp;
  } dam_row_t;
  // src = {short, ring init, ring ok, sel a[1:0], sel b[1:0]}
  localparam dam_row_t ROWS [9] = '{
    '{7'h00, 8'h64, 32'h0000_0000, 1'b0}, '{7'h40, 8'h65, 32'h0002_0000, 1'b1},
    '{7'h20, 8'h93, 32'h0000_4000, 1'b1}, '{7'h30, 8'h94, 32'h0000_0000, 1'b0},
    '{7'h08, 8'h00, 32'h0004_0000, 1'b0}, '{7'h04, 8'h00, 32'h0040_0000, 1'b0},
    '{7'h02, 8'h00, 32'h0008_0000, 1'b0}, '{7'h01, 8'h00, 32'h0080_0000, 1'b0},
    '{7'h6F, 8'hFF, 32'h00CE_4000, 1'b0}};

  logic         core_clk, rst_b, reg_we, reg_re, brush, bearing, short_det;
  logic         ring_init, ring_ok, clr, irq, present, no_alarm, supp;
  logic         led_b, led_c, showing;
  logic [7:0]   reg_addr, fault_code, letter, led_flips, bad;
  logic [31:0]  reg_wdata, rdata, cw2, seen;
  logic [1:0]   sel_a, sel_b;
  logic [4:0]   op_state;
  logic [15:0]  sw1;
  logic [127:0] conn;
  logic [11:0]  code_b, code_c;
  int           num_errors = 0;
  int           n_tests = 0;

  dam_alarm_monitor #(.BRUSH_CYC(34'd20), .BEARING_CYC(34'd10), .FLASH_CYC(34'd4),
    .HOLD_CYC(34'd5), .CYC_PER_MS(2)) dam_alarm_monitor_inst (
    .CORE_CLK(core_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_we), .REG_RD(reg_re), .REG_RDATA(rdata), .IRQ(irq), .CONTROL_WORD2(cw2),
    .BLOCK_ALARM_SELECT_A(sel_a), .BLOCK_ALARM_SELECT_B(sel_b), .BRUSH_SENSE(brush),
    .BEARING_SENSE(bearing), .SHORT_DETECT(short_det), .RING_INIT_DONE(ring_init),
    .RING_EXCHANGE_OK(ring_ok), .OP_STATE(op_state), .FAULT_CODE(fault_code),
    .ALARM_PRESENT_BIT(present), .NO_ALARM_BIT(no_alarm), .STATUS_WORD1(sw1),
    .ALARM_CONNECTORS(conn), .SUPP_FAULT(supp), .BASIC_PANEL_LED(led_b),
    .COMFORT_PANEL_LED(led_c), .BASIC_PANEL_LETTER(letter), .BASIC_PANEL_CODE(code_b),
    .COMFORT_PANEL_CODE(code_c), .PANEL_SHOWING(showing));

  dam_panel_model dam_panel_model_inst (.clk(core_clk), .clr(clr), .showing(showing),
    .letter(letter), .code(code_b), .led_a(led_b), .led_b(led_c), .seen(seen),
    .code_c(code_c), .led_flips(led_flips), .bad(bad));

  task automatic check(input string nm, input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge core_clk);
    reg_we    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge core_clk);
    reg_re   <= 1'b0;
    #1;
    check(nm, 128'(rdata), 128'(exp));
  endtask

  task automatic drive(input int src, input logic v);
    case (src)
      0: cw2[DAM_CW2_EXT1_BIT] <= v;
      1: cw2[DAM_CW2_EXT2_BIT] <= v;
      2: brush <= v;
      default: bearing <= v;
    endcase
  endtask

  // Low for lim+1 samples raises the alarm one edge later; high clears it
  task automatic timed(input int src, input int lim, input int bi, input logic on);
    @(posedge core_clk);
    drive(src, 1'b0);
    repeat (lim + 1) @(posedge core_clk);
    #1;
    check("timer early", 128'(conn[bi]), 128'(1'b0));
    @(posedge core_clk);
    #1;
    check("timer due", 128'(conn[bi]), 128'(on));
    @(posedge core_clk);
    drive(src, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check("timer clear", 128'(conn[bi]), 128'(1'b0));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #40000;
    num_errors++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    cw2 = 32'hFFFF_FFFF;
    sel_a = '0;
    sel_b = '0;
    brush = 1'b1;
    bearing = 1'b1;
    short_det = 1'b0;
    ring_init = 1'b0;
    ring_ok = 1'b0;
    op_state = '0;
    fault_code = '0;
    clr = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check("reset flags", 128'({present, no_alarm, irq, led_b}), 128'(4'b0100));
    @(posedge core_clk);
    rst_b <= 1'b1;
    bus_rd(DAM_A_CTRL, 32'h0, "ctrl reset");
    bus_rd(DAM_A_DLY1, 32'h0, "delay one reset");
    bus_rd(DAM_A_DLY2, 32'h0, "delay two reset");
    bus_rd(DAM_A_IMASK, 32'h0, "mask reset");
    bus_wr(DAM_A_STATUS, 32'hFFFF_FFFF);
    bus_rd(DAM_A_STATUS, 32'h2, "status read only");
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      {short_det, ring_init, ring_ok, sel_a, sel_b} <= ROWS[i].src;
      fault_code <= ROWS[i].fc;
      op_state <= 5'(i * 3);
      repeat (3) @(posedge core_clk);
      #1;
      check("alarm words", conn, 128'(ROWS[i].exp));
      check("present", 128'({present, no_alarm}), 128'({|ROWS[i].exp, ~|ROWS[i].exp}));
      check("status word", 128'(sw1), 128'({|ROWS[i].exp, 7'h00}));
      check("supp fault", 128'(supp), 128'(ROWS[i].supp));
    end
    bus_rd(DAM_A_WORDS, 32'h00CE_4000, "words reg");
    @(posedge core_clk);
    {short_det, ring_init, ring_ok, sel_a, sel_b} <= 7'h00;
    bus_wr(DAM_A_DLY1, 32'd3);
    bus_wr(DAM_A_DLY2, 32'd1);
    bus_wr(DAM_A_CTRL, 32'h3);
    timed(0, 3 * MS, 20, 1'b1);
    timed(1, 1 * MS, 21, 1'b1);
    timed(2, BR_L, 24, 1'b1);
    timed(3, BE_L, 25, 1'b1);
    bus_wr(DAM_A_CTRL, 32'h0);
    timed(2, BR_L, 24, 1'b0);
    timed(3, BE_L, 25, 1'b0);
    bus_rd(DAM_A_ISTAT, 32'h3FF, "all slots rose");
    bus_wr(DAM_A_IMASK, 32'h2);
    @(posedge core_clk);
    short_det <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("irq short", 128'(irq), 128'(1'b1));
    bus_rd(DAM_A_ISTAT, 32'h2, "istat short");
    check("irq cleared", 128'(irq), 128'(1'b0));
    bus_rd(DAM_A_STATUS, 32'h0000_0061, "status code");
    @(posedge core_clk);
    short_det <= 1'b0;
    ring_init <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("irq masked", 128'(irq), 128'(1'b0));
    bus_rd(DAM_A_ISTAT, 32'h1, "istat ring");
    @(posedge core_clk);
    ring_init <= 1'b0;
    bus_wr(8'hFC, 32'hFFFF_FFFF);
    bus_rd(8'hFC, 32'h0, "unmapped");
    bus_rd(DAM_A_IMASK, 32'h2, "mask kept");
    @(posedge core_clk);
    #1;
    check("rdata idle", 128'(rdata), 128'(0));
    @(posedge core_clk);
    short_det <= 1'b1;
    sel_a <= 2'b01;
    clr <= 1'b0;
    repeat (60) @(posedge core_clk);
    #1;
    check("codes shown", 128'(seen), 128'(32'h0084_0000));
    check("panel faults", 128'(bad), 128'(0));
    check("led flashing", 128'(led_flips > 8'd5), 128'(1'b1));
    @(posedge core_clk);
    short_det <= 1'b0;
    sel_a <= 2'b00;
    repeat (4) @(posedge core_clk);
    #1;
    check("panel idle", 128'({led_b, showing, no_alarm}), 128'(3'b001));
    @(posedge core_clk);
    short_det <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b0;
    #1;
    check("mid reset", 128'({present, no_alarm}), 128'(2'b01));
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("after reset", 128'({present, no_alarm}), 128'(2'b10));
    print_verdict();
  end
endmodule
